// ===== verilog/motor_status_bank.sv
// status register bank with spi slave of the stepper driver
`timescale 1ns/10ps
module motor_status_bank #(
  parameter logic [4:0] DEVICE_CODE = motor_status_pkg::DEVICE_CODE_DFLT,
  parameter logic [2:0] REVISION_CODE = motor_status_pkg::REVISION_CODE_DFLT
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic spi_clk_i,
  input wire logic chip_sel_n_i,
  input wire logic spi_data_i,
  output logic spi_data_o,
  output logic error_output_line_o,
  output logic error_output_line_oe_n_o,
  input wire motor_status_pkg::fault_evt_s fault_evt_i,
  input wire motor_status_pkg::live_s live_i,
  input wire logic step_pulse_pin_i,
  input wire logic direction_pin_i,
  input wire logic undervoltage_response_select_i,
  output logic bridge_float_o,
  output logic bridge_brake_o
);
  import motor_status_pkg::*;

  typedef struct packed {
    logic csb_meta;
    logic csb_sync;
    logic csb_prev;
    logic step_meta;
    logic step_sync;
    logic dir_meta;
    logic dir_sync;
    latch_s flags;
    logic [3:0] frame_base;
    logic [FRAME_BITS-1:0] tx_word;
    logic err_oe_n;
    logic drive_low;
    logic bridge_float;
    logic bridge_brake;
  } sys_s;

  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [3:0] edge_cnt;
  } link_s;

  localparam sys_s SYS_RST = '{
    csb_meta: 1'b1,
    csb_sync: 1'b1,
    csb_prev: 1'b1,
    step_meta: 1'b0,
    step_sync: 1'b0,
    dir_meta: 1'b0,
    dir_sync: 1'b0,
    flags: '{ev: '0, spi_error: 1'b0, hard_reset: HARD_RESET_FLAG_RST},
    frame_base: 4'h0,
    tx_word: '0,
    err_oe_n: 1'b1,
    drive_low: 1'b0,
    bridge_float: 1'b0,
    bridge_brake: 1'b0
  };

  sys_s s_r;
  sys_s s_nxt;
  link_s l_r;
  link_s l_nxt;
  logic miso_r;
  logic miso_clr;

  // byte plus odd check bit; bit 9 stays zero
  function automatic logic [9:0] odd_word(input logic [7:0] b);
    odd_word = {1'b0, ~(^b), b};
  endfunction : odd_word

  function automatic logic defect_summary(input fault_evt_s f);
    defect_summary = (|f.coil_x_short) | (|f.coil_y_short) | f.coil_x_open | f.coil_y_open;
  endfunction : defect_summary

  // byte of a status register, before the check bit is added
  function automatic logic [7:0] status_byte(input logic [4:0] addr, input latch_s f, input live_s lv,
                                             input logic step_lvl, input logic dir_lvl);
    logic [7:0] b;
    b = 8'h00;
    case (addr)
      ADDR_MAIN_FAULT: begin
        b[B_STALL] = f.ev.stall;
        b[B_SUPPLY_LOW] = f.ev.supply_low;
        b[B_THERM_WARN] = lv.thermal_warning;
        b[B_UV_WARN] = f.ev.undervoltage_warning;
        b[B_LOW_TEMP] = lv.low_temp_boost_ok;
        b[B_ELECTRICAL_DEFECT_SUMMARY] = defect_summary(f.ev);
        b[B_HARD_RST] = f.hard_reset;
        b[B_STEP_LOSS] = f.ev.step_loss;
      end
      ADDR_COIL_X: begin
        b[3:0] = f.ev.coil_x_short;
        b[B_OPEN] = f.ev.coil_x_open;
        b[B_TSD] = f.ev.thermal_shutdown;
        b[B_SPI_ERR] = f.spi_error;
      end
      ADDR_COIL_Y_PIN: begin
        b[3:0] = f.ev.coil_y_short;
        b[B_OPEN] = f.ev.coil_y_open;
        b[B_DIR_PIN] = dir_lvl;
        b[B_STEP_PIN] = step_lvl;
      end
      ADDR_IDENTITY: begin
        b = {DEVICE_CODE, REVISION_CODE};
      end
      ADDR_BACKEMF: begin
        b[4:0] = lv.backemf_value;
        b[B_BEMF_POL] = lv.backemf_wrong_polarity;
        b[B_BEMF_COIL] = lv.backemf_coil_select;
        b[B_BEMF_READY] = f.ev.backemf_result_ready;
      end
      ADDR_SPEED: begin
        b = lv.velocity_count;
      end
      default: begin
        b = 8'h00;
      end
    endcase
    status_byte = b;
  endfunction : status_byte

  // latches that a read of the given register clears
  function automatic latch_s clear_mask(input logic [4:0] addr);
    latch_s m;
    m = '0;
    case (addr)
      ADDR_MAIN_FAULT: begin
        m.ev.stall = 1'b1;
        m.ev.supply_low = 1'b1;
        m.ev.undervoltage_warning = 1'b1;
        m.ev.step_loss = 1'b1;
        m.hard_reset = 1'b1;
      end
      ADDR_COIL_X: begin
        m.ev.coil_x_short = 4'hf;
        m.ev.coil_x_open = 1'b1;
        m.ev.thermal_shutdown = 1'b1;
        m.spi_error = 1'b1;
      end
      ADDR_COIL_Y_PIN: begin
        m.ev.coil_y_short = 4'hf;
        m.ev.coil_y_open = 1'b1;
      end
      ADDR_BACKEMF: begin
        m.ev.backemf_result_ready = 1'b1;
      end
      default: begin
        m = '0;
      end
    endcase
    clear_mask = m;
  endfunction : clear_mask

  // link side: runs only while the master clocks a frame
  always_comb begin
    l_nxt = l_r;
    if (!chip_sel_n_i) begin
      l_nxt.shift = {l_r.shift[FRAME_BITS-2:0], spi_data_i};
      l_nxt.edge_cnt = 4'(l_r.edge_cnt + 4'h1);
    end
  end

  always_ff @(posedge spi_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // answer bit changes on the falling edge; bit 15 of the answer is always zero,
  // which is what the cleared flop shows before the first rising edge
  assign miso_clr = sys_rst_i | chip_sel_n_i;

  always_ff @(negedge spi_clk_i or posedge miso_clr) begin
    if (miso_clr) begin
      miso_r <= 1'b0;
    end else begin
      miso_r <= s_r.tx_word[~(4'(l_r.edge_cnt - s_r.frame_base))];
    end
  end

  // system side
  logic frame_end;
  logic [3:0] frame_len;
  logic [4:0] frm_addr;
  logic frm_write;
  logic parity_ok;
  logic frame_err;
  logic read_ok;
  latch_s set_v;
  latch_s clr_v;
  latch_s flags_v;
  logic [9:0] word_v;

  always_comb begin
    s_nxt = s_r;
    // link words are stable here: chip select is high and the link clock idle
    frame_end = s_r.csb_sync & ~s_r.csb_prev;
    frame_len = 4'(l_r.edge_cnt - s_r.frame_base);
    frm_addr = l_r.shift[FRAME_BITS-1:FRM_ADDR_LO];
    frm_write = l_r.shift[FRM_WRITE];
    parity_ok = ^l_r.shift;
    frame_err = (frame_len != 4'h0)
              | ~parity_ok
              | (~frm_write & (|l_r.shift[FRM_ZERO_W-1:0]));
    read_ok = frame_end & ~frame_err & ~frm_write;

    s_nxt.csb_meta = chip_sel_n_i;
    s_nxt.csb_sync = s_r.csb_meta;
    s_nxt.csb_prev = s_r.csb_sync;
    s_nxt.step_meta = step_pulse_pin_i;
    s_nxt.step_sync = s_r.step_meta;
    s_nxt.dir_meta = direction_pin_i;
    s_nxt.dir_sync = s_r.dir_meta;

    set_v = '0;
    set_v.ev = fault_evt_i;
    set_v.spi_error = frame_end & frame_err;
    clr_v = read_ok ? clear_mask(frm_addr) : latch_s'('0);
    flags_v = latch_s'((s_r.flags & ~clr_v) | set_v);
    s_nxt.flags = flags_v;

    word_v = odd_word(status_byte(frm_addr, s_r.flags, live_i, s_r.step_sync, s_r.dir_sync));
    if (frame_end) begin
      s_nxt.frame_base = l_r.edge_cnt;
      // answer goes out in the next frame; writes and bad frames answer zero
      s_nxt.tx_word = read_ok ? {6'h00, word_v} : '0;
    end

    s_nxt.drive_low = flags_v.spi_error | flags_v.ev.thermal_shutdown
                    | flags_v.ev.supply_low | defect_summary(flags_v.ev);
    s_nxt.err_oe_n = ~s_nxt.drive_low;
    s_nxt.bridge_float = flags_v.ev.supply_low & ~undervoltage_response_select_i;
    s_nxt.bridge_brake = flags_v.ev.supply_low & undervoltage_response_select_i;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= SYS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign spi_data_o = miso_r;
  // open-drain line only ever pulls low
  assign error_output_line_o = 1'b0;
  assign error_output_line_oe_n_o = s_r.err_oe_n;
  assign bridge_float_o = s_r.bridge_float;
  assign bridge_brake_o = s_r.bridge_brake;

endmodule : motor_status_bank

// ===== verilog/motor_status_pkg.sv
// constants, field layouts and carrier types of the motor driver status bank
package motor_status_pkg;

  localparam logic [4:0] ADDR_MAIN_FAULT = 5'h05;
  localparam logic [4:0] ADDR_COIL_X = 5'h06;
  localparam logic [4:0] ADDR_COIL_Y_PIN = 5'h07;
  localparam logic [4:0] ADDR_IDENTITY = 5'h08;
  localparam logic [4:0] ADDR_BACKEMF = 5'h09;
  localparam logic [4:0] ADDR_SPEED = 5'h0a;

  // frame layout, msb first on the wire
  localparam int FRAME_BITS = 16;
  localparam int FRM_ADDR_LO = 11;
  localparam int FRM_PAR = 10;
  localparam int FRM_WRITE = 9;
  localparam int FRM_ZERO_W = 9;

  // status word fields
  localparam int WORD_PAR_BIT = 8;
  localparam int B_STALL = 0;
  localparam int B_SUPPLY_LOW = 1;
  localparam int B_THERM_WARN = 2;
  localparam int B_UV_WARN = 3;
  localparam int B_LOW_TEMP = 4;
  localparam int B_ELECTRICAL_DEFECT_SUMMARY = 5;
  localparam int B_HARD_RST = 6;
  localparam int B_STEP_LOSS = 7;
  localparam int B_OPEN = 4;
  localparam int B_TSD = 5;
  localparam int B_SPI_ERR = 6;
  localparam int B_DIR_PIN = 5;
  localparam int B_STEP_PIN = 6;
  localparam int DEV_CODE_LO = 3;
  localparam int B_BEMF_POL = 5;
  localparam int B_BEMF_COIL = 6;
  localparam int B_BEMF_READY = 7;

  localparam logic HARD_RESET_FLAG_RST = 1'b1;
  // arbitrary identification values
  localparam logic [4:0] DEVICE_CODE_DFLT = 5'h0b;
  localparam logic [2:0] REVISION_CODE_DFLT = 3'h6;

  // least chip-select high time, in system clocks, for the end-of-frame handover
  localparam int CSB_IDLE_MIN_CYCLES = 4;

  // short bits: {pos_to_ground, neg_to_ground, pos_to_supply, neg_to_supply}
  typedef logic [3:0] short_t;

  typedef struct packed {
    logic stall;
    logic step_loss;
    logic supply_low;
    logic undervoltage_warning;
    logic thermal_shutdown;
    logic coil_x_open;
    logic coil_y_open;
    short_t coil_x_short;
    short_t coil_y_short;
    logic backemf_result_ready;
  } fault_evt_s;

  typedef struct packed {
    logic thermal_warning;
    logic low_temp_boost_ok;
    logic backemf_coil_select;
    logic backemf_wrong_polarity;
    logic [4:0] backemf_value;
    logic [7:0] velocity_count;
  } live_s;

  typedef struct packed {
    fault_evt_s ev;
    logic spi_error;
    logic hard_reset;
  } latch_s;

endpackage : motor_status_pkg

// ===== verif/motor_status_bank_properties.sv
// port assertions of the motor status bank
`timescale 1ns/10ps
module motor_status_bank_properties (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic chip_sel_n_i,
  input wire logic spi_data_o,
  input wire logic error_output_line_o,
  input wire logic error_output_line_oe_n_o,
  input wire motor_status_pkg::fault_evt_s fault_evt_i,
  input wire logic undervoltage_response_select_i,
  input wire logic bridge_float_o,
  input wire logic bridge_brake_o
);
  import motor_status_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_uv_bridge: assert property (fault_evt_i.supply_low |-> ##[1:2] (bridge_float_o | bridge_brake_o))
    else $error("bridge idle after undervoltage");
  a_brake_sel: assert property (bridge_brake_o |-> $past(undervoltage_response_select_i))
    else $error("brake without brake select");
  a_bridge_excl: assert property (!(bridge_float_o && bridge_brake_o))
    else $error("float and brake together");
  a_od_value: assert property (error_output_line_o == 1'b0)
    else $error("open drain value not low");
  a_short_err: assert property ((|fault_evt_i.coil_x_short) | (|fault_evt_i.coil_y_short)
    |-> ##[1:2] !error_output_line_oe_n_o) else $error("short not on error line");
  a_tsd_err: assert property (fault_evt_i.thermal_shutdown |-> ##[1:2] !error_output_line_oe_n_o)
    else $error("shutdown not on error line");
  a_idle_quiet: assert property (chip_sel_n_i && $past(chip_sel_n_i) |-> !spi_data_o)
    else $error("data out busy outside frame");
  a_uv_hold: assert property ((bridge_float_o | bridge_brake_o) && !chip_sel_n_i ##1 !chip_sel_n_i
    |=> (bridge_float_o | bridge_brake_o)) else $error("undervoltage dropped in frame");
  a_err_hold: assert property (!error_output_line_oe_n_o && !chip_sel_n_i ##1 !chip_sel_n_i
    |=> !error_output_line_oe_n_o) else $error("error line freed in frame");
  c_brake: cover property (fault_evt_i.supply_low ##2 bridge_brake_o);
  c_release: cover property ($rose(error_output_line_oe_n_o));
  c_tsd: cover property (fault_evt_i.thermal_shutdown);
endmodule : motor_status_bank_properties

// ===== verif/spi_master_model.sv
// spi master standing in for the controlling microcontroller
`timescale 1ns/10ps
module spi_master_model (
  output logic spi_clk_o,
  output logic chip_sel_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    spi_clk_o = 1'b0;
    chip_sel_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  // clock stands still between frames; short frames send the low bits
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    chip_sel_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_o = tx[i];
      #24;
      spi_clk_o = 1'b1;
      rx = {rx[14:0], miso_i};
      #24;
      spi_clk_o = 1'b0;
    end
    #24;
    chip_sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    // idle gap well above the least chip-select high time
    #150;
  endtask : xfer
endmodule : spi_master_model

// ===== verif/testbench.sv
// self-checking bench of the motor status bank
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module testbench;
  import motor_status_pkg::*;
  logic clock_i, sys_rst_i, spi_clk, csb, mosi, miso, err_o, err_oe_n, uv_sel, fl, br, step_pin, dir_pin;
  fault_evt_s evt;
  live_s live;
  logic [15:0] rx;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  // pulled-up open-drain line
  wire err_line = err_oe_n ? 1'b1 : err_o;
  motor_status_bank motor_status_bank_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .spi_clk_i(spi_clk),
    .chip_sel_n_i(csb), .spi_data_i(mosi), .spi_data_o(miso), .error_output_line_o(err_o),
    .error_output_line_oe_n_o(err_oe_n), .fault_evt_i(evt), .live_i(live), .step_pulse_pin_i(step_pin),
    .direction_pin_i(dir_pin), .undervoltage_response_select_i(uv_sel), .bridge_float_o(fl), .bridge_brake_o(br));
  spi_master_model spi_master_model_inst (.spi_clk_o(spi_clk), .chip_sel_n_o(csb), .mosi_o(mosi), .miso_i(miso));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  function automatic logic [15:0] rd_frame(input logic [4:0] a);
    return {a, ~^a, 1'b0, 9'h000};
  endfunction : rd_frame
  function automatic logic [15:0] word(input logic [7:0] v);
    return {7'h00, ~^v, v};
  endfunction : word
  // answer seen belongs to the previous frame
  task automatic rd(input logic [4:0] a, input logic [15:0] ex, input string nm);
    spi_master_model_inst.xfer(rd_frame(a), 16, rx);
    `CHK(nm, ex, rx)
  endtask : rd
  task automatic t_reset_id;
    rd(ADDR_MAIN_FAULT, 16'h0000, "first");
    rd(ADDR_IDENTITY, word(8'h54), "sr1 reset");
    rd(ADDR_SPEED, word({DEVICE_CODE_DFLT, REVISION_CODE_DFLT}), "identity");
    rd(ADDR_MAIN_FAULT, word(8'ha5), "speed");
    rd(ADDR_BACKEMF, word(8'h14), "sr1 again");
    rd(5'h00, word(8'h55), "backemf idle");
  endtask : t_reset_id
  task automatic t_latches;
    @(negedge clock_i);
    uv_sel = 1'b1;
    evt = '1;
    @(negedge clock_i);
    evt = '0;
    repeat (3) @(negedge clock_i);
    `CHK("brake", 1'b1, br)
    `CHK("float", 1'b0, fl)
    `CHK("err line", 1'b0, err_line)
    rd(ADDR_MAIN_FAULT, 16'h0100, "unmapped");
    rd(ADDR_MAIN_FAULT, word(8'hbf), "sr1 set");
    rd(ADDR_COIL_X, word(8'h34), "sr1 kept");
    rd(ADDR_COIL_Y_PIN, word(8'h3f), "sr2");
    rd(ADDR_BACKEMF, word(8'h5f), "sr3");
    rd(ADDR_COIL_X, word(8'hd5), "sr5");
    rd(ADDR_MAIN_FAULT, word(8'h00), "sr2 clear");
    rd(5'h00, word(8'h14), "sr1 clear");
    `CHK("brake off", 1'b0, br)
  endtask : t_latches
  task automatic t_spi_err;
    spi_master_model_inst.xfer(rd_frame(ADDR_COIL_X), 15, rx);
    spi_master_model_inst.xfer(rd_frame(ADDR_COIL_X) ^ 16'h0400, 16, rx);
    `CHK("odd count", 16'h0000, rx)
    `CHK("err held", 1'b0, err_line)
    spi_master_model_inst.xfer(rd_frame(ADDR_COIL_X) | 16'h0003, 16, rx);
    `CHK("bad parity", 16'h0000, rx)
    rd(ADDR_COIL_X, 16'h0000, "nonzero field");
    rd(5'h00, word(8'h40), "spi flag");
    `CHK("err free", 1'b1, err_line)
    rd(ADDR_COIL_X, 16'h0100, "unmapped");
    rd(5'h00, word(8'h00), "spi cleared");
  endtask : t_spi_err
  task automatic t_live_write;
    @(negedge clock_i);
    uv_sel = 1'b0;
    evt.supply_low = 1'b1;
    live = {1'b0, 1'b0, 1'b0, 1'b1, 5'h0a, 8'h3c};
    step_pin = 1'b0;
    dir_pin = 1'b1;
    @(negedge clock_i);
    evt = '0;
    repeat (3) @(negedge clock_i);
    `CHK("float on", 1'b1, fl)
    `CHK("brake idle", 1'b0, br)
    rd(ADDR_MAIN_FAULT, 16'h0100, "unmapped");
    rd(ADDR_COIL_Y_PIN, word(8'h02), "sr1 live");
    `CHK("float off", 1'b0, fl)
    rd(ADDR_BACKEMF, word(8'h20), "sr3 pins");
    rd(ADDR_SPEED, word(8'h2a), "sr5 live");
    // legal write: no control registers here, so it answers zero and flags nothing
    spi_master_model_inst.xfer({5'h01, 1'b1, 1'b1, 9'h0aa}, 16, rx);
    `CHK("speed live", word(8'h3c), rx)
    rd(ADDR_COIL_X, 16'h0000, "write answer");
    rd(5'h00, word(8'h00), "write no error");
  endtask : t_live_write
  task automatic t_mid_reset;
    @(negedge clock_i);
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rd(ADDR_MAIN_FAULT, 16'h0000, "reset answer");
    rd(ADDR_MAIN_FAULT, word(8'h40), "hard reset");
    rd(5'h00, word(8'h00), "hard reset clear");
  endtask : t_mid_reset
  initial begin
    sys_rst_i = 1'b1;
    evt = '0;
    live = {1'b1, 1'b1, 1'b1, 1'b0, 5'h15, 8'ha5};
    uv_sel = 1'b0;
    step_pin = 1'b1;
    dir_pin = 1'b0;
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    t_reset_id();
    t_latches();
    t_spi_err();
    t_live_write();
    t_mid_reset();
    wrap_up();
  end
endmodule : testbench
bind motor_status_bank motor_status_bank_properties props_inst (.clock_i, .sys_rst_i, .chip_sel_n_i, .spi_data_o,
  .error_output_line_o, .error_output_line_oe_n_o, .fault_evt_i, .undervoltage_response_select_i,
  .bridge_float_o, .bridge_brake_o);
